/* sadc_clk_div.sv */
`timescale 1ns/1ps
module sadc_clk_div (
    // clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // control
    input wire logic run,
    input wire logic [2:0] divide,
    // one-cycle tick per conversion clock
    output logic tick
);

    logic [3:0] count_reg;
    logic [3:0] terminal;

    assign terminal = sadc_pkg::divide_terminal(divide);

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            count_reg <= 4'h0;
        end else if (!run || count_reg >= terminal) begin
            count_reg <= 4'h0;
        end else begin
            count_reg <= count_reg + 4'h1;
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            tick <= 1'b0;
        end else begin
            tick <= run && (count_reg >= terminal);
        end
    end

endmodule

/* sadc_conv_ctrl.sv */
`timescale 1ns/1ps
module sadc_conv_ctrl (
    // clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // special function register bus
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    // system events
    input wire logic timer_overflow,
    input wire logic chip_standby,
    input wire logic irq_enable,
    output logic conv_irq,
    // analog converter core
    output logic analog_power,
    output logic track_en,
    output logic conv_clk_tick,
    output logic core_start,
    input wire logic core_done,
    input wire logic [11:0] core_result,
    output logic [5:0] gain_onehot,
    // port pin routing
    output logic [31:0] pin_analog_sel
);

    sadc_pkg::sadc_sel_s sel_reg;
    sadc_pkg::sadc_cfg_s cfg_reg;
    sadc_pkg::sadc_ctl_s ctl_reg;
    sadc_pkg::sadc_state_e state_reg;
    logic [11:0] result_reg;
    logic [1:0] track_cnt_reg;
    logic busy;
    logic wr_sel;
    logic wr_cfg;
    logic wr_ctl;
    logic sw_start;
    logic tmr_start;
    logic start;
    logic finish;
    logic div_tick;
    logic [7:0] result_high;
    logic [7:0] result_low;

    assign wr_sel = sfr_wr && (sfr_addr == sadc_pkg::ADDR_INPUT_SELECT);
    assign wr_cfg = sfr_wr && (sfr_addr == sadc_pkg::ADDR_CONFIG);
    assign wr_ctl = sfr_wr && (sfr_addr == sadc_pkg::ADDR_CONTROL);
    assign busy = (state_reg != sadc_pkg::ST_IDLE);

    // start sources, reserved modes start nothing
    assign sw_start = wr_ctl && sfr_wdata[sadc_pkg::CTL_BUSY_BIT]
        && (ctl_reg.start_mode == sadc_pkg::START_SOFTWARE);
    assign tmr_start = timer_overflow
        && (ctl_reg.start_mode == sadc_pkg::START_TIMER);
    assign start = ctl_reg.enable && !busy && (sw_start || tmr_start);
    assign finish = (state_reg == sadc_pkg::ST_CONV) && core_done;

    // input select register, top bits dropped
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sel_reg <= sadc_pkg::sadc_sel_s'(sadc_pkg::RST_INPUT_SELECT[5:0]);
        end else if (wr_sel) begin
            sel_reg <= sadc_pkg::sadc_sel_s'(sfr_wdata[5:0]);
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cfg_reg <= sadc_pkg::sadc_cfg_s'({sadc_pkg::RST_CONFIG[7:5],
                sadc_pkg::RST_CONFIG[2:0]});
        end else if (wr_cfg) begin
            cfg_reg <= sadc_pkg::sadc_cfg_s'({sfr_wdata[7:5], sfr_wdata[2:0]});
        end
    end

    // control bits other than busy, done included
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctl_reg.enable <= sadc_pkg::RST_CONTROL[sadc_pkg::CTL_ENABLE_BIT];
            ctl_reg.track_mode <= sadc_pkg::RST_CONTROL[sadc_pkg::CTL_TRACK_MODE_BIT];
            ctl_reg.start_mode <= sadc_pkg::RST_CONTROL[sadc_pkg::CTL_START_LSB +: 2];
            ctl_reg.left_justify <= sadc_pkg::RST_CONTROL[sadc_pkg::CTL_LJUST_BIT];
            ctl_reg.done <= sadc_pkg::RST_CONTROL[sadc_pkg::CTL_DONE_BIT];
        end else begin
            if (wr_ctl) begin
                ctl_reg.enable <= sfr_wdata[sadc_pkg::CTL_ENABLE_BIT];
                ctl_reg.track_mode <= sfr_wdata[sadc_pkg::CTL_TRACK_MODE_BIT];
                ctl_reg.start_mode <= sfr_wdata[sadc_pkg::CTL_START_LSB +: 2];
                ctl_reg.left_justify <= sfr_wdata[sadc_pkg::CTL_LJUST_BIT];
            end
            // done flag: completion wins over a software clear
            if (finish) begin
                ctl_reg.done <= 1'b1;
            end else if (wr_ctl) begin
                ctl_reg.done <= sfr_wdata[sadc_pkg::CTL_DONE_BIT];
            end
        end
    end

    // conversion sequencer
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg <= sadc_pkg::ST_IDLE;
        end else if (!ctl_reg.enable) begin
            state_reg <= sadc_pkg::ST_IDLE;
        end else begin
            case (state_reg)
                sadc_pkg::ST_IDLE: begin
                    if (start && ctl_reg.track_mode) begin
                        state_reg <= sadc_pkg::ST_TRACK;
                    end else if (start) begin
                        state_reg <= sadc_pkg::ST_CONV;
                    end
                end
                sadc_pkg::ST_TRACK: begin
                    if (div_tick && track_cnt_reg == sadc_pkg::TRACK_CLOCKS - 2'h1) begin
                        state_reg <= sadc_pkg::ST_CONV;
                    end
                end
                sadc_pkg::ST_CONV: begin
                    if (core_done) begin
                        state_reg <= sadc_pkg::ST_IDLE;
                    end
                end
                default: begin
                    state_reg <= sadc_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // conversion clocks spent tracking
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            track_cnt_reg <= 2'h0;
        end else if (state_reg != sadc_pkg::ST_TRACK) begin
            track_cnt_reg <= 2'h0;
        end else if (div_tick) begin
            track_cnt_reg <= track_cnt_reg + 2'h1;
        end
    end

    // one pulse to the core when conversion phase begins
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            core_start <= 1'b0;
        end else begin
            core_start <= ctl_reg.enable && (
                (state_reg == sadc_pkg::ST_IDLE && start && !ctl_reg.track_mode)
                || (state_reg == sadc_pkg::ST_TRACK && div_tick
                    && track_cnt_reg == sadc_pkg::TRACK_CLOCKS - 2'h1));
        end
    end

    // result captured in the same edge as the done flag
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            result_reg <= sadc_pkg::RST_RESULT;
        end else if (finish) begin
            result_reg <= core_result;
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            conv_irq <= 1'b0;
        end else begin
            conv_irq <= finish && irq_enable;
        end
    end

    sadc_clk_div u_clk_div (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .run(ctl_reg.enable),
        .divide(cfg_reg.divide),
        .tick(div_tick)
    );

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            conv_clk_tick <= 1'b0;
        end else begin
            conv_clk_tick <= div_tick;
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            analog_power <= 1'b0;
        end else begin
            analog_power <= ctl_reg.enable;
        end
    end

    // continuous tracking when idle, or windowed tracking
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            track_en <= 1'b0;
        end else begin
            track_en <= ctl_reg.enable && !chip_standby && (ctl_reg.track_mode ?
                (state_reg == sadc_pkg::ST_TRACK) :
                (state_reg == sadc_pkg::ST_IDLE));
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            gain_onehot <= 6'h00;
        end else begin
            gain_onehot <= sadc_pkg::gain_decode(cfg_reg.gain);
        end
    end

    // one select line per port pin
    generate
        for (genvar i = 0; i < sadc_pkg::NUM_PINS; i++) begin : g_pin
            always_ff @(posedge sys_clk or posedge sys_rst) begin
                if (sys_rst) begin
                    pin_analog_sel[i] <= 1'b0;
                end else begin
                    pin_analog_sel[i] <= sel_reg.mux_en
                        && ({sel_reg.port, sel_reg.pin} == 5'(i));
                end
            end
        end
    endgenerate

    // justified result bytes
    always_comb begin
        if (ctl_reg.left_justify) begin
            result_high = result_reg[11:4];
            result_low = {result_reg[3:0], 4'h0};
        end else begin
            result_high = {4'h0, result_reg[11:8]};
            result_low = result_reg[7:0];
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sfr_rdata <= 8'h00;
        end else if (sfr_rd) begin
            case (sfr_addr)
                sadc_pkg::ADDR_INPUT_SELECT: sfr_rdata <= {2'h0, sel_reg};
                sadc_pkg::ADDR_CONFIG: sfr_rdata <= {cfg_reg.divide, 2'h0, cfg_reg.gain};
                sadc_pkg::ADDR_CONTROL: sfr_rdata <= {ctl_reg.enable, ctl_reg.track_mode,
                    ctl_reg.done, busy, ctl_reg.start_mode, 1'b0, ctl_reg.left_justify};
                sadc_pkg::ADDR_RESULT_HIGH: sfr_rdata <= result_high;
                sadc_pkg::ADDR_RESULT_LOW: sfr_rdata <= result_low;
                default: sfr_rdata <= 8'h00;
            endcase
        end
    end

endmodule

/* sadc_conv_ctrl_bench.sv */
`timescale 1ns/1ps
module sadc_conv_ctrl_bench;
    localparam logic [7:0] SEL = sadc_pkg::ADDR_INPUT_SELECT;
    localparam logic [7:0] CFG = sadc_pkg::ADDR_CONFIG;
    localparam logic [7:0] CTL = sadc_pkg::ADDR_CONTROL;
    localparam logic [7:0] RHI = sadc_pkg::ADDR_RESULT_HIGH;
    localparam logic [7:0] RLO = sadc_pkg::ADDR_RESULT_LOW;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] sfr_addr = 8'h00;
    logic sfr_wr = 1'b0;
    logic sfr_rd = 1'b0;
    logic [7:0] sfr_wdata = 8'h00;
    logic [7:0] sfr_rdata;
    logic timer_overflow = 1'b0;
    logic chip_standby = 1'b0;
    logic irq_enable = 1'b0;
    logic conv_irq, analog_power, track_en, conv_clk_tick, core_start, core_done;
    logic [11:0] core_result;
    logic [11:0] next_result = 12'h000;
    logic [5:0] gain_onehot;
    logic [31:0] pin_analog_sel;
    int err_count = 0;
    int cmp_count = 0;
    int irq_cnt = 0;
    initial begin
        forever #50 sys_clk = ~sys_clk;
    end
    sadc_conv_ctrl sadc_conv_ctrl_inst (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
        .sfr_rdata(sfr_rdata), .timer_overflow(timer_overflow),
        .chip_standby(chip_standby), .irq_enable(irq_enable), .conv_irq(conv_irq),
        .analog_power(analog_power), .track_en(track_en), .conv_clk_tick(conv_clk_tick),
        .core_start(core_start), .core_done(core_done), .core_result(core_result),
        .gain_onehot(gain_onehot), .pin_analog_sel(pin_analog_sel));
    sadc_core_model sadc_core_model_inst (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .core_start(core_start), .next_result(next_result), .core_done(core_done),
        .core_result(core_result));
    always @(negedge sys_clk) begin
        if (conv_irq === 1'b1) begin
            irq_cnt++;
        end
    end
    task automatic close_out();
        $display("mismatches %0d of %0d checks", err_count, cmp_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(negedge sys_clk);
        sfr_wr = 1'b0;
        @(negedge sys_clk);
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp, input string msg);
        sfr_addr = a;
        sfr_rd = 1'b1;
        @(negedge sys_clk);
        sfr_rd = 1'b0;
        chk(sfr_rdata, exp, msg);
        @(negedge sys_clk);
    endtask
    task automatic wait_done();
        for (int i = 0; i < 100; i++) begin
            sfr_addr = CTL;
            sfr_rd = 1'b1;
            @(negedge sys_clk);
            sfr_rd = 1'b0;
            @(negedge sys_clk);
            if (sfr_rdata[5] === 1'b1) return;
        end
        chk(1'b0, 1'b1, "conversion timeout");
        close_out();
    endtask
    task automatic tick_gap(output int n);
        n = 0;
        do begin
            @(negedge sys_clk);
            n++;
        end while (conv_clk_tick !== 1'b1 && n < 40);
    endtask
    task automatic t_reset();
        rchk(SEL, 8'h00, "select reset");
        rchk(CFG, 8'h60, "config reset");
        rchk(CTL, 8'h00, "control reset");
        rchk(RHI, 8'h00, "result reset");
        rchk(8'h55, 8'h00, "unmapped read");
        chk(gain_onehot, 6'h02, "gain after reset");
    endtask
    task automatic t_select();
        wr(SEL, 8'hff);
        rchk(SEL, 8'h3f, "select top bits");
        // pins taken as already in analog input mode
        for (int i = 0; i < 32; i++) begin
            wr(SEL, 8'h20 | 8'(i));
            chk(pin_analog_sel, 32'h1 << i, "pin routing");
        end
        wr(SEL, 8'h1f);
        chk(pin_analog_sel, 32'h0, "mux off");
    endtask
    task automatic t_gain();
        logic [5:0] g [8] = '{6'h02, 6'h04, 6'h08, 6'h10, 6'h20, 6'h20, 6'h01, 6'h01};
        for (int c = 0; c < 8; c++) begin
            wr(CFG, 8'h18 | 8'(c));
            chk(gain_onehot, g[c], "gain code");
            rchk(CFG, 8'(c), "config unused bits");
        end
    endtask
    task automatic t_div();
        int codes [6] = '{0, 1, 2, 3, 4, 7};
        int n;
        for (int k = 0; k < 6; k++) begin
            wr(CFG, 8'(codes[k] << 5));
            wr(CTL, 8'hc0);
            chk(track_en, 1'b0, "idle low power track");
            wr(CTL, 8'hd0);
            chk(track_en, 1'b1, "track after start");
            tick_gap(n);
            tick_gap(n);
            chk(n, codes[k] > 3 ? 16 : 1 << codes[k], "divide ratio");
            wait_done();
        end
    endtask
    task automatic t_soft();
        int k;
        wr(CFG, 8'h00);
        irq_enable = 1'b1;
        wr(CTL, 8'h80);
        chk(track_en, 1'b1, "continuous tracking");
        next_result = 12'hc3a;
        k = irq_cnt;
        wr(CTL, 8'h90);
        rchk(CTL, 8'h90, "busy during conversion");
        wait_done();
        rchk(CTL, 8'ha0, "busy clear done set");
        chk(irq_cnt, k + 1, "interrupt raised");
        rchk(RHI, 8'h0c, "right high");
        rchk(RLO, 8'h3a, "right low");
        wr(CTL, 8'h81);
        rchk(RHI, 8'hc3, "left high");
        rchk(RLO, 8'ha0, "left low");
        irq_enable = 1'b0;
        wr(CTL, 8'h90);
        wait_done();
        chk(irq_cnt, k + 1, "interrupt masked");
        wr(CTL, 8'h84);
        wr(CTL, 8'h94);
        rchk(CTL, 8'h84, "reserved mode no start");
    endtask
    task automatic t_timer();
        wr(CTL, 8'hcc);
        next_result = 12'h5e1;
        timer_overflow = 1'b1;
        @(negedge sys_clk);
        timer_overflow = 1'b0;
        @(negedge sys_clk);
        chk(track_en, 1'b1, "timer tracking");
        wait_done();
        rchk(RLO, 8'he1, "timer result");
        wr(CTL, 8'hdc);
        rchk(CTL, 8'hcc, "busy write in timer mode");
    endtask
    task automatic t_power();
        wr(CTL, 8'h80);
        chip_standby = 1'b1;
        repeat (2) @(negedge sys_clk);
        chk(track_en, 1'b0, "standby tracking");
        chip_standby = 1'b0;
        wr(CTL, 8'h00);
        chk(analog_power, 1'b0, "shutdown");
    endtask
    initial begin
        repeat (6) @(negedge sys_clk);
        sys_rst = 1'b0;
        t_reset();
        t_select();
        t_gain();
        t_div();
        t_soft();
        t_timer();
        t_power();
        close_out();
    end
endmodule

/* sadc_conv_ctrl_properties.sv */
`timescale 1ns/1ps
module sadc_conv_ctrl_properties (
    // clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // register bus
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata,
    // system events
    input wire logic timer_overflow,
    input wire logic chip_standby,
    input wire logic irq_enable,
    input wire logic conv_irq,
    // converter core and pins
    input wire logic analog_power,
    input wire logic track_en,
    input wire logic conv_clk_tick,
    input wire logic core_start,
    input wire logic core_done,
    input wire logic [11:0] core_result,
    input wire logic [5:0] gain_onehot,
    input wire logic [31:0] pin_analog_sel
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    logic conv_reg;
    logic wr_sel;
    logic wr_cfg;
    logic wr_ctl;
    assign wr_sel = sfr_wr && sfr_addr == sadc_pkg::ADDR_INPUT_SELECT;
    assign wr_cfg = sfr_wr && sfr_addr == sadc_pkg::ADDR_CONFIG;
    assign wr_ctl = sfr_wr && sfr_addr == sadc_pkg::ADDR_CONTROL;
    function automatic logic [5:0] gexp(input logic [2:0] c);
        return c[2] ? (c[1] ? 6'h01 : 6'h20) : 6'h02 << c[1:0];
    endfunction
    // conversion in flight, from start pulse to done pulse
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            conv_reg <= 1'b0;
        end else if (core_start) begin
            conv_reg <= 1'b1;
        end else if (core_done || !analog_power) begin
            conv_reg <= 1'b0;
        end
    end
    a_select_route: assert property (
        wr_sel |-> ##2 pin_analog_sel ==
        ($past(sfr_wdata[5], 2) ? 32'h1 << $past(sfr_wdata[4:0], 2) : 32'h0))
        else $error("pin routing wrong");
    a_pin_single: assert property ($onehot0(pin_analog_sel))
        else $error("more than one analog pin");
    a_gain_map: assert property (
        wr_cfg |-> ##2 gain_onehot == gexp($past(sfr_wdata[2:0], 2)))
        else $error("gain decode wrong");
    a_power_enable: assert property (
        wr_ctl |-> ##2 analog_power == $past(sfr_wdata[7], 2))
        else $error("power does not follow enable");
    a_off_quiet: assert property (
        !analog_power [*3] |-> !track_en && !core_start)
        else $error("activity while powered down");
    a_start_idle: assert property (
        core_start |-> analog_power && !conv_reg)
        else $error("start while busy or off");
    a_done_irq: assert property (
        conv_reg && core_done && irq_enable |=> conv_irq)
        else $error("missing completion interrupt");
    a_irq_cause: assert property (
        conv_irq |-> $past(core_done && irq_enable && conv_reg))
        else $error("spurious interrupt");
    a_conv_hold: assert property (core_start |=> !track_en [*2])
        else $error("tracking during conversion");
    a_standby_track: assert property (chip_standby |=> !track_en)
        else $error("tracking in standby");
    c_start: cover property (core_start);
    c_irq: cover property (conv_irq);
    c_route: cover property (wr_sel ##2 pin_analog_sel != 32'h0);
endmodule
bind sadc_conv_ctrl sadc_conv_ctrl_properties sadc_conv_ctrl_properties_inst (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .timer_overflow(timer_overflow), .chip_standby(chip_standby),
    .irq_enable(irq_enable), .conv_irq(conv_irq), .analog_power(analog_power),
    .track_en(track_en), .conv_clk_tick(conv_clk_tick), .core_start(core_start),
    .core_done(core_done), .core_result(core_result), .gain_onehot(gain_onehot),
    .pin_analog_sel(pin_analog_sel)
);

/* sadc_core_model.sv */
`timescale 1ns/1ps
module sadc_core_model #(
    parameter int LAT = 5
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // from control
    input wire logic core_start,
    input wire logic [11:0] next_result,
    // to control
    output logic core_done,
    output logic [11:0] core_result
);
    int cnt;
    // result valid only with done, a toggling pattern otherwise
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt <= 0;
            core_done <= 1'b0;
            core_result <= 12'h000;
        end else begin
            core_done <= (cnt == 1);
            core_result <= (cnt == 1) ? next_result : ~core_result;
            if (core_start) begin
                cnt <= LAT;
            end else if (cnt > 0) begin
                cnt <= cnt - 1;
            end
        end
    end
endmodule

/* sadc_pkg.sv */
package sadc_pkg;

    // register addresses on the special function register bus
    localparam logic [7:0] ADDR_INPUT_SELECT = 8'hbb;
    localparam logic [7:0] ADDR_CONFIG = 8'hbc;
    localparam logic [7:0] ADDR_CONTROL = 8'he8;
    localparam logic [7:0] ADDR_RESULT_HIGH = 8'hbf;
    localparam logic [7:0] ADDR_RESULT_LOW = 8'hbe;

    // reset values
    localparam logic [7:0] RST_INPUT_SELECT = 8'h00;
    localparam logic [7:0] RST_CONFIG = 8'h60;
    localparam logic [7:0] RST_CONTROL = 8'h00;
    localparam logic [11:0] RST_RESULT = 12'h000;

    // input select field positions
    localparam int SEL_MUX_EN_BIT = 5;
    localparam int SEL_PORT_LSB = 3;
    localparam int SEL_PIN_LSB = 0;

    // config field positions
    localparam int CFG_DIV_LSB = 5;
    localparam int CFG_GAIN_LSB = 0;

    // control field positions
    localparam int CTL_ENABLE_BIT = 7;
    localparam int CTL_TRACK_MODE_BIT = 6;
    localparam int CTL_DONE_BIT = 5;
    localparam int CTL_BUSY_BIT = 4;
    localparam int CTL_START_LSB = 2;
    localparam int CTL_LJUST_BIT = 0;

    // start modes
    localparam logic [1:0] START_SOFTWARE = 2'h0;
    localparam logic [1:0] START_TIMER = 2'h3;

    // tracking window in conversion clocks
    localparam logic [1:0] TRACK_CLOCKS = 2'h3;

    localparam int NUM_PINS = 32;
    localparam int PINS_PER_PORT = 8;

    typedef struct packed {
        logic mux_en;
        logic [1:0] port;
        logic [2:0] pin;
    } sadc_sel_s;

    typedef struct packed {
        logic [2:0] divide;
        logic [2:0] gain;
    } sadc_cfg_s;

    typedef struct packed {
        logic enable;
        logic track_mode;
        logic done;
        logic [1:0] start_mode;
        logic left_justify;
    } sadc_ctl_s;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_TRACK = 3'b010,
        ST_CONV = 3'b100
    } sadc_state_e;

    // gain one-hot: [0]=0.5 [1]=1 [2]=2 [3]=4 [4]=8 [5]=16
    function automatic logic [5:0] gain_decode(input logic [2:0] code);
        logic [5:0] g;
        g = 6'h00;
        case (code)
            3'h0: g = 6'h02;
            3'h1: g = 6'h04;
            3'h2: g = 6'h08;
            3'h3: g = 6'h10;
            3'h4, 3'h5: g = 6'h20;
            default: g = 6'h01;
        endcase
        return g;
    endfunction

    // terminal count of the conversion clock divider (ratio minus one)
    function automatic logic [3:0] divide_terminal(input logic [2:0] code);
        logic [3:0] t;
        t = 4'h0;
        case (code)
            3'h0: t = 4'h0;
            3'h1: t = 4'h1;
            3'h2: t = 4'h3;
            3'h3: t = 4'h7;
            default: t = 4'hf;
        endcase
        return t;
    endfunction

endpackage
